// *** design/tmr_pkg.sv ***
// Purpose: constants and types for the reload/capture timer
// Assumes: 8-bit special-function register port, one system clock
// Notes: control bit positions follow the control register layout
package tmr_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int BIT_HIGH_OVF = 7;
  localparam int BIT_LOW_OVF = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_XCLK_HI = 1;
  localparam int BIT_XCLK_LO = 0;
  localparam logic [1:0] XCLK_DIV12 = 2'h0;
  localparam logic [1:0] XCLK_RTC8 = 2'h1;
  localparam logic [1:0] XCLK_RESERVED = 2'h2;
  localparam logic [1:0] XCLK_CMP = 2'h3;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [2:0] RTC_DIV_LAST = 3'h7;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [15:0] WORD_ALL_ONES = 16'hFFFF;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_idx;
    logic bit_val;
  } tmr_sfr_req_t;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [3:0] div12;
    logic [2:0] rtc_div;
    logic [2:0] rtc_sync;
    logic [2:0] cmp_sync;
    logic irq;
    logic [7:0] rdata;
  } tmr_state_t;
endpackage

// *** design/tmr_timer2.sv ***
// Purpose: 16-bit / dual 8-bit auto-reload timer with capture
// Assumes: pins rtc_clk and cmp0_out are asynchronous to clk
// Notes: read data appears one cycle after sfr.rd
// How it works
// - count is low byte plus high byte
// - split bit clear gives one 16-bit reload counter
// - 16-bit wrap reloads both bytes, sets high flag
// - timer irq enable interrupts on 16-bit overflow
// - low irq enable adds low byte wrap interrupts
// - split gives two 8-bit reload timers
// - split: run gates high byte only
// - clock select: system clock or external table
// - rtc/8 and comparator synced to system clock
// - split: each byte wrap sets its flag
// - split: interrupt on high, or either byte
// - flags cleared only by software writes or reset
// - capture enable bit enters capture mode
// - capture on comparator rise or 8 rtc cycles
// - capture copies count to reload, sets flag
// - control register at 0xC8, resets zero, RW
// - low byte wrap sets low flag always
`timescale 1ns/1ps
module tmr_timer2
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // special-function register port
  input wire tmr_sfr_req_t sfr,
  output logic [7:0] sfr_rdata,
  // clock selects and cpu interrupt enable
  input wire logic high_byte_clock_select,
  input wire logic low_byte_clock_select,
  input wire logic timer_irq_enable,
  // asynchronous pins
  input wire logic rtc_clk,
  input wire logic cmp0_out,
  // interrupt request
  output logic irq_req
);
  tmr_state_t s, next_s;

  logic tick_div12, tick_rtc8, rise_cmp, tick_low, tick_high, cap_ev;
  logic split, run, cap_en;
  logic [1:0] xclk;
  logic [15:0] count16;
  logic wr_ctrl, wr_cl, wr_ch, wr_rl, wr_rh;
  logic set_h, set_l;

  assign split = s.control[BIT_SPLIT];
  assign run = s.control[BIT_RUN];
  assign cap_en = s.control[BIT_CAPTURE_EN];
  assign xclk = s.control[BIT_XCLK_HI:BIT_XCLK_LO];
  assign count16 = {s.count_high_byte, s.count_low_byte};
  assign wr_ctrl = (sfr.wr || sfr.bit_wr) && sfr.addr == ADDR_CONTROL;
  assign wr_cl = sfr.wr && sfr.addr == ADDR_COUNT_LOW;
  assign wr_ch = sfr.wr && sfr.addr == ADDR_COUNT_HIGH;
  assign wr_rl = sfr.wr && sfr.addr == ADDR_RELOAD_LOW;
  assign wr_rh = sfr.wr && sfr.addr == ADDR_RELOAD_HIGH;

  // edges taken from the second sync stage and a third history stage
  assign tick_div12 = s.div12 == DIV12_LAST;
  assign rise_cmp = s.cmp_sync[1] && !s.cmp_sync[2];
  assign tick_rtc8 = s.rtc_sync[1] && !s.rtc_sync[2] && s.rtc_div == RTC_DIV_LAST;

  function automatic logic src_tick(input logic use_sys, input logic [1:0] sel,
                                    input logic t12, input logic trtc, input logic tcmp);
    logic t;
    t = 1'b0;
    if (use_sys) begin
      t = 1'b1;
    end else begin
      case (sel)
        XCLK_DIV12: t = t12;
        XCLK_RTC8: t = trtc;
        XCLK_CMP: t = tcmp;
        default: t = 1'b0;
      endcase
    end
    return t;
  endfunction

  assign tick_low = src_tick(low_byte_clock_select, xclk, tick_div12, tick_rtc8, rise_cmp);
  assign tick_high = src_tick(high_byte_clock_select, xclk, tick_div12, tick_rtc8, rise_cmp);
  // capture source picked by the upper external select bit
  assign cap_ev = cap_en && (xclk[1] ? rise_cmp : tick_rtc8);

  always_comb begin
    next_s = s;
    set_h = 1'b0;
    set_l = 1'b0;
    next_s.div12 = tick_div12 ? 4'h0 : s.div12 + 4'h1;
    next_s.rtc_sync = {s.rtc_sync[1:0], rtc_clk};
    next_s.cmp_sync = {s.cmp_sync[1:0], cmp0_out};
    if (s.rtc_sync[1] && !s.rtc_sync[2]) begin
      next_s.rtc_div = s.rtc_div + 3'h1;
    end
    if (wr_cl) begin
      next_s.count_low_byte = sfr.wdata;
    end
    if (wr_ch) begin
      next_s.count_high_byte = sfr.wdata;
    end
    if (wr_rl) begin
      next_s.reload_low_byte = sfr.wdata;
    end
    if (wr_rh) begin
      next_s.reload_high_byte = sfr.wdata;
    end
    if (!split) begin
      if (run && tick_low) begin
        if (count16 == WORD_ALL_ONES) begin
          {next_s.count_high_byte, next_s.count_low_byte} =
            {s.reload_high_byte, s.reload_low_byte};
          set_h = 1'b1;
          set_l = 1'b1;
        end else begin
          {next_s.count_high_byte, next_s.count_low_byte} = count16 + 16'h0001;
          set_l = s.count_low_byte == BYTE_ALL_ONES;
        end
      end
    end else begin
      if (tick_low) begin
        if (s.count_low_byte == BYTE_ALL_ONES) begin
          next_s.count_low_byte = s.reload_low_byte;
          set_l = 1'b1;
        end else begin
          next_s.count_low_byte = s.count_low_byte + 8'h01;
        end
      end
      if (run && tick_high) begin
        if (s.count_high_byte == BYTE_ALL_ONES) begin
          next_s.count_high_byte = s.reload_high_byte;
          set_h = 1'b1;
        end else begin
          next_s.count_high_byte = s.count_high_byte + 8'h01;
        end
      end
    end
    if (cap_ev) begin
      next_s.reload_high_byte = s.count_high_byte;
      next_s.reload_low_byte = s.count_low_byte;
      set_h = 1'b1;
    end
    if (wr_ctrl) begin
      if (sfr.bit_wr) begin
        next_s.control[sfr.bit_idx] = sfr.bit_val;
      end else begin
        next_s.control = sfr.wdata;
      end
    end
    // a hardware set beats a same-cycle software clear
    if (set_h) begin
      next_s.control[BIT_HIGH_OVF] = 1'b1;
    end
    if (set_l) begin
      next_s.control[BIT_LOW_OVF] = 1'b1;
    end
    // level request; the flags decide, software sorts the source
    next_s.irq = timer_irq_enable && (next_s.control[BIT_HIGH_OVF] ||
      (next_s.control[BIT_LOW_IRQ_EN] && next_s.control[BIT_LOW_OVF]));
    if (sfr.rd) begin
      case (sfr.addr)
        ADDR_CONTROL: next_s.rdata = s.control;
        ADDR_RELOAD_LOW: next_s.rdata = s.reload_low_byte;
        ADDR_RELOAD_HIGH: next_s.rdata = s.reload_high_byte;
        ADDR_COUNT_LOW: next_s.rdata = s.count_low_byte;
        ADDR_COUNT_HIGH: next_s.rdata = s.count_high_byte;
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.control <= CONTROL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign sfr_rdata = s.rdata;
  assign irq_req = s.irq;

  // checks
  sequence s_wrap16;
    !split && run && tick_low && count16 == WORD_ALL_ONES && !cap_ev && !wr_rl && !wr_rh;
  endsequence

  property p_wrap16;
    @(posedge clk) disable iff (!rst_n)
      s_wrap16 |=> count16 == {$past(s.reload_high_byte), $past(s.reload_low_byte)}
        && s.control[BIT_HIGH_OVF];
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap did not reload");

  property p_low_free;
    @(posedge clk) disable iff (!rst_n)
      split && !run && tick_low && s.count_low_byte != BYTE_ALL_ONES && !wr_cl
        |=> s.count_low_byte == $past(s.count_low_byte) + 8'h01;
  endproperty
  a_low_free: assert property (p_low_free) else $error("low byte stalled in split");

  property p_high_gated;
    @(posedge clk) disable iff (!rst_n)
      split && !run && !wr_ch |=> s.count_high_byte == $past(s.count_high_byte);
  endproperty
  a_high_gated: assert property (p_high_gated) else $error("stopped high byte moved");

  property p_low_flag;
    @(posedge clk) disable iff (!rst_n)
      tick_low && s.count_low_byte == BYTE_ALL_ONES && (split || run)
        |=> s.control[BIT_LOW_OVF];
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low wrap left flag clear");

  property p_sticky;
    @(posedge clk) disable iff (!rst_n)
      s.control[BIT_HIGH_OVF] && !wr_ctrl |=> s.control[BIT_HIGH_OVF];
  endproperty
  a_sticky: assert property (p_sticky) else $error("high flag cleared by hardware");

  property p_capture;
    @(posedge clk) disable iff (!rst_n)
      cap_ev |=> {s.reload_high_byte, s.reload_low_byte} == $past(count16)
        && s.control[BIT_HIGH_OVF];
  endproperty
  a_capture: assert property (p_capture) else $error("capture did not copy count");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
      !split && !low_byte_clock_select && xclk == XCLK_RESERVED && !wr_cl && !wr_ch
        |=> count16 == $past(count16);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved source counted");

  property p_div12;
    @(posedge clk) disable iff (!rst_n)
      tick_div12 |=> !tick_div12 [*8] ##1 !tick_div12 [*3] ##1 tick_div12;
  endproperty
  a_div12: assert property (p_div12) else $error("divide-by-12 tick misspaced");

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      timer_irq_enable && s.control[BIT_HIGH_OVF] && !wr_ctrl |=> irq_req;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow flag raised no request");

  property p_irq_off;
    @(posedge clk) disable iff (!rst_n)
      !timer_irq_enable |=> !irq_req;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request without enable");

  // a running 16-bit count steps by one between wraps
  property p_count16;
    @(posedge clk) disable iff (!rst_n)
      !split && run && tick_low && count16 != WORD_ALL_ONES
        |=> count16 == $past(count16) + 16'h0001;
  endproperty
  a_count16: assert property (p_count16) else $error("16-bit count skipped");

  sequence s_low_wrap_split;
    split && tick_low && s.count_low_byte == BYTE_ALL_ONES;
  endsequence

  property p_low_reload;
    @(posedge clk) disable iff (!rst_n)
      s_low_wrap_split |=> s.count_low_byte == $past(s.reload_low_byte)
        && s.control[BIT_LOW_OVF];
  endproperty
  a_low_reload: assert property (p_low_reload) else $error("low reload lost");

  sequence s_high_wrap_split;
    split && run && tick_high && s.count_high_byte == BYTE_ALL_ONES;
  endsequence

  property p_high_reload;
    @(posedge clk) disable iff (!rst_n)
      s_high_wrap_split |=> s.count_high_byte == $past(s.reload_high_byte)
        && s.control[BIT_HIGH_OVF];
  endproperty
  a_high_reload: assert property (p_high_reload) else $error("high reload lost");

  property p_sticky_low;
    @(posedge clk) disable iff (!rst_n)
      s.control[BIT_LOW_OVF] && !wr_ctrl |=> s.control[BIT_LOW_OVF];
  endproperty
  a_sticky_low: assert property (p_sticky_low) else $error("low flag lost");

  property p_irq_low;
    @(posedge clk) disable iff (!rst_n)
      timer_irq_enable && s.control[BIT_LOW_IRQ_EN] && s.control[BIT_LOW_OVF] && !wr_ctrl
        |=> irq_req;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("low flag raised no request");

  // two flops between the pins and any edge detect
  property p_cmp_sync;
    @(posedge clk) disable iff (!rst_n)
      rise_cmp |-> $past(cmp0_out, 2);
  endproperty
  a_cmp_sync: assert property (p_cmp_sync) else $error("comparator edge too early");

  property p_rtc_sync;
    @(posedge clk) disable iff (!rst_n)
      tick_rtc8 |-> $past(rtc_clk, 2);
  endproperty
  a_rtc_sync: assert property (p_rtc_sync) else $error("rtc tick too early");

  property p_rdata;
    @(posedge clk) disable iff (!rst_n)
      sfr.rd && sfr.addr == ADDR_CONTROL |=> sfr_rdata == $past(s.control);
  endproperty
  a_rdata: assert property (p_rdata) else $error("control read back wrong");
endmodule

// *** dv/test_tmr_timer2.sv ***
// Purpose: self-checking bench for the reload/capture timer
// Assumes: clock selects and cpu irq enable are driven here as plain pins
// Notes: reads scored from a queue; masks absorb sync and divider phase
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_tmr_timer2
  import tmr_pkg::*;
;
  logic clk;
  logic rst_n;
  tmr_sfr_req_t sfr;
  logic [7:0] sfr_rdata;
  logic hsel;
  logic lsel;
  logic irq_en;
  logic rtc_clk;
  logic cmp0_out;
  logic irq_req;
  logic rd_pend;
  logic [15:0] note;
  logic [15:0] exp_q[$];
  logic [31:0] lfsr;
  logic [7:0] v;
  logic [1:0] srcs[3];
  logic [7:0] cnts[3];
  logic [1:0] caps[2];
  int num_errors;
  int num_checks;

  tmr_timer2 uut (.clk(clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .high_byte_clock_select(hsel), .low_byte_clock_select(lsel),
    .timer_irq_enable(irq_en), .rtc_clk(rtc_clk), .cmp0_out(cmp0_out), .irq_req(irq_req));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // read data lands one cycle after the strobe
  always @(posedge clk) rd_pend <= sfr.rd;
  always @(negedge clk) begin
    if (rd_pend === 1'b1) begin
      note = exp_q.pop_front();
      `CHK(sfr_rdata & note[15:8], note[7:0])
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // idle edge after each access so no strobe is set twice in one step
  task automatic put(input tmr_sfr_req_t r);
    sfr = r;
    tick(1);
    sfr = '0;
    tick(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put('{wr: 1'b1, addr: a, wdata: d, default: '0});
  endtask

  task automatic bset(input logic [2:0] i);
    put('{bit_wr: 1'b1, addr: ADDR_CONTROL, bit_idx: i, bit_val: 1'b1, default: '0});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    put('{rd: 1'b1, addr: a, default: '0});
  endtask

  task automatic run_sys(input int n);
    hsel = 1'b1;
    lsel = 1'b1;
    tick(n);
    hsel = 1'b0;
    lsel = 1'b0;
  endtask

  // spacing kept wide so the two-flop syncs see every edge
  task automatic pulses(input int n, input logic on_rtc);
    repeat (n) begin
      lfsr = lfsr_next(lfsr);
      if (on_rtc) rtc_clk = 1'b1;
      else cmp0_out = 1'b1;
      tick(4 + lfsr[2:0]);
      rtc_clk = 1'b0;
      cmp0_out = 1'b0;
      tick(4 + lfsr[5:3]);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    tick(40000);
    num_errors++;
    test_done();
  end

  initial begin
    sfr = '0;
    hsel = 1'b0;
    lsel = 1'b0;
    irq_en = 1'b0;
    rtc_clk = 1'b0;
    cmp0_out = 1'b0;
    rst_n = 1'b0;
    lfsr = 32'h5747;
    num_errors = 0;
    num_checks = 0;
    srcs = '{XCLK_DIV12, XCLK_RTC8, XCLK_CMP};
    cnts = '{8'h08, 8'h02, 8'h05};
    caps = '{XCLK_CMP, XCLK_RTC8};
    tick(6);
    rst_n = 1'b1;
    rd(ADDR_CONTROL, 8'hFF, CONTROL_RESET);
    // run set so only the reserved source can hold the count still
    wr(ADDR_CONTROL, {6'h01, XCLK_RESERVED});
    wr(ADDR_COUNT_LOW, 8'h00);
    tick(30);
    rd(ADDR_COUNT_LOW, 8'hFF, 8'h00);
    rd(8'hC9, 8'hFF, 8'h00);
    lfsr = lfsr_next(lfsr);
    v = {2'b00, lfsr[3:0], XCLK_RESERVED};
    wr(ADDR_CONTROL, v);
    rd(ADDR_CONTROL, 8'hFF, v);
    bset(3'h6);
    rd(ADDR_CONTROL, 8'hFF, v | 8'h40);
    foreach (srcs[i]) begin
      wr(ADDR_CONTROL, {6'h01, srcs[i]});
      wr(ADDR_COUNT_LOW, 8'h00);
      if (i == 0) tick(126);
      else pulses(i == 1 ? 16 : 5, i == 1);
      rd(ADDR_COUNT_LOW, i == 0 ? 8'hFC : 8'hFF, cnts[i]);
    end
    irq_en = 1'b1;
    wr(ADDR_CONTROL, 8'h06);
    wr(ADDR_RELOAD_LOW, 8'h34);
    wr(ADDR_RELOAD_HIGH, 8'h12);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hF8);
    run_sys(20);
    rd(ADDR_COUNT_HIGH, 8'hFF, 8'h12);
    rd(ADDR_CONTROL, 8'hC0, 8'hC0);
    `CHK(irq_req, 1'b1)
    tick(50);
    rd(ADDR_CONTROL, 8'hC0, 8'hC0);
    wr(ADDR_CONTROL, 8'h26);
    `CHK(irq_req, 1'b0)
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hF8);
    run_sys(20);
    rd(ADDR_CONTROL, 8'hC0, 8'h40);
    `CHK(irq_req, 1'b1)
    wr(ADDR_CONTROL, 8'h0A);
    wr(ADDR_RELOAD_HIGH, 8'h60);
    wr(ADDR_COUNT_HIGH, 8'hF8);
    wr(ADDR_COUNT_LOW, 8'hF8);
    run_sys(20);
    rd(ADDR_COUNT_HIGH, 8'hFF, 8'hF8);
    rd(ADDR_CONTROL, 8'hC0, 8'h40);
    `CHK(irq_req, 1'b0)
    bset(3'h5);
    `CHK(irq_req, 1'b1)
    bset(3'h2);
    run_sys(14);
    rd(ADDR_COUNT_HIGH, 8'hF0, 8'h60);
    rd(ADDR_CONTROL, 8'hC0, 8'hC0);
    foreach (caps[i]) begin
      wr(ADDR_CONTROL, {6'h05, caps[i]});
      wr(ADDR_RELOAD_HIGH, 8'hAA);
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h00);
      lsel = 1'b1;
      pulses(caps[i][1] ? 1 : 8, !caps[i][1]);
      lsel = 1'b0;
      rd(ADDR_RELOAD_HIGH, 8'hFF, 8'h00);
      rd(ADDR_CONTROL, 8'h80, 8'h80);
      `CHK(irq_req, 1'b1)
    end
    // two captures one comparator period apart; the read adds two cycles
    wr(ADDR_CONTROL, {6'h05, XCLK_CMP});
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h00);
    lsel = 1'b1;
    pulses(1, 1'b0);
    v = 8'h0C + lfsr[2:0] + lfsr[5:3];
    rd(ADDR_RELOAD_LOW, 8'hFF, 8'h02);
    pulses(1, 1'b0);
    lsel = 1'b0;
    rd(ADDR_RELOAD_LOW, 8'hFF, v);
    // mid-run reset must drop the flags and the request
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
    `CHK(irq_req, 1'b0)
    rd(ADDR_CONTROL, 8'hFF, CONTROL_RESET);
    test_done();
  end
endmodule
